// [hdl/acp_params.svh]
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH
// ==========================================================================
// Serial port constants
// Idle timeouts in system clock cycles
`define ACP_TMO_SHORT 256
`define ACP_TMO_LONG 4096
// Power-up recovery idle time: 2^18 + 4096 system clock cycles
`define ACP_RECOVER_CYCLES 266240
// Command opcodes in the top three bits of the command byte
`define ACP_OP_RESULT 3'h1
`define ACP_OP_REG_RD 3'h2
`define ACP_OP_REG_WR 3'h3
// Idle data-input patterns that select a direct result read
`define ACP_DIRECT_LO 3'h0
`define ACP_DIRECT_HI 3'h7
// Last register address of a multiple access
`define ACP_LAST_REG 4'h9
// Bit counts
`define ACP_DIRECT_BITS 6'h03
`define ACP_CMD_BITS 6'h08
`define ACP_FRAME_DATA 6'h18
`define ACP_FRAME_STAT 6'h20
`define ACP_FRAME_CMD 6'h28
`define ACP_BYTE_LAST 3'h7
`endif

// [hdl/acp_pkg.sv]
// ==========================================================================
// Types of the serial command port
package acp_pkg;

  // Port sequencing states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DIRECT,
    ST_CMD_END,
    ST_RESULT,
    ST_REG_RD,
    ST_REG_WR,
    ST_HOLD
  } acp_state_e;

  // Conversion result handed over by the converter core
  typedef struct packed {
    logic [6:0] flags;
    logic [23:0] data;
  } acp_result_s;

  // Command byte layout
  typedef struct packed {
    logic [2:0] op;
    logic multi_access_bit;
    logic [3:0] addr;
  } acp_cmd_s;

endpackage : acp_pkg

// [hdl/acp_sync2.sv]
`timescale 1ns/100ps
// ==========================================================================
// Two flip-flop synchroniser for asynchronous pins
module acp_sync2 #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule : acp_sync2

// [hdl/acp_serial_port.sv]
`timescale 1ns/100ps
`include "acp_params.svh"
// Contract
// - Select high aborts transfer, resets port, floats output, ignores input.
// - Data-ready strobe is driven whatever select does.
// - Input sampled on rising clock, output changes on falling clock.
// - Clock idle 256 or 4096 cycles ends transfer and resets port.
// - Direct read must finish before next strobe; new result replaces old.
// - Command result read any time; fresh flag shows update since read.
// - Result goes out MSB first right after the status byte.
// - Port recovers on reset, select pulse or long clock idle.
// - First three input bits 000 or 111 start a direct read.
// - After direct read, commands ignored until select, timeout or reset.
// - Direct read runs 24 clocks, or 32 with status byte.
// - First output bit stands before the strobe falls.
// - Second direct read in one strobe period returns zero data.
// - Result read starts at eighth falling edge, 40 clocks, no corruption.
// - Register data from eighth falling edge, byte per eight; stop at 09h.
module acp_serial_port
  import acp_pkg::*;
#(
  parameter int TMO_SHORT = `ACP_TMO_SHORT,
  parameter int TMO_LONG = `ACP_TMO_LONG,
  parameter int RECOVER_CYCLES = `ACP_RECOVER_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  // Converter core side
  input wire logic conv_valid_i,
  input wire acp_result_s conv_result_i,
  output logic result_ready_strobe_n_o,
  // Configuration bits
  input wire logic idle_timeout_select_i,
  input wire logic status_enable_i,
  // Register file access
  output logic [3:0] reg_addr_o,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o
);

  localparam int CW = $clog2(RECOVER_CYCLES + 1);

  // ========================================================================
  // Pin synchronisation and clock edges
  logic [2:0] pins_s;
  logic sclk_d_r;

  acp_sync2 #(.WIDTH(3)) u_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .d_i({~cs_n_i, sclk_i, din_i}), // Select inverted: reset reads idle
    .q_o(pins_s)
  );

  wire logic cs_s = ~pins_s[2];
  wire logic sclk_s = pins_s[1];
  wire logic din_s = pins_s[0];
  wire logic rise = sclk_s & ~sclk_d_r;
  wire logic fall = ~sclk_s & sclk_d_r;

  // ========================================================================
  // Clock idle timeouts
  logic [CW-1:0] tmo_r;
  wire logic [CW-1:0] tmo_lim = idle_timeout_select_i ?
      CW'(TMO_LONG - 1) : CW'(TMO_SHORT - 1);
  wire logic tmo_hit = (tmo_r == tmo_lim) |
      (tmo_r == CW'(RECOVER_CYCLES - 1));
  wire logic tmo_sat = (tmo_r == CW'(RECOVER_CYCLES));
  wire logic [CW-1:0] tmo_nxt = (rise | fall | cs_s) ? '0 :
      (tmo_sat ? tmo_r : tmo_r + CW'(1));
  // Select high or clock idle puts the port back to rest
  wire logic port_rst = cs_s | tmo_hit;

  // ========================================================================
  // State registers
  acp_state_e state_r, state_nxt;
  logic [31:0] shift_r, shift_nxt;
  logic [5:0] rise_r, rise_nxt;
  logic [5:0] fall_r, fall_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [3:0] addr_r, addr_nxt;
  logic last_r, last_nxt;
  logic wr_r, wr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  acp_result_s result_r;
  logic fresh_r;
  logic direct_done_r;
  logic [2:0] new_d_r;
  logic result_ready_strobe_n_n_r;
  logic dout_r;
  logic dout_oe_r;
  logic take_result;
  logic mark_direct;

  // ========================================================================
  // Frame and command decoding
  wire logic [7:0] cmd_byte = {cmd_r[6:0], din_s};
  wire acp_cmd_s cmd_in = acp_cmd_s'(cmd_byte);
  wire acp_cmd_s cmd_hold = acp_cmd_s'(cmd_r);
  wire logic [2:0] head3 = {cmd_r[1:0], din_s};
  wire logic direct_pat = (head3 == `ACP_DIRECT_LO) |
      (head3 == `ACP_DIRECT_HI);
  wire logic [7:0] status_byte = {fresh_r, result_r.flags};
  // Repeat direct read in the same period shows zero data
  wire logic [23:0] direct_data = direct_done_r ? 24'h000000 :
      result_r.data;
  wire logic [31:0] direct_frame = status_enable_i ?
      {status_byte, direct_data} : {direct_data, 8'h00};
  wire logic [5:0] direct_len = status_enable_i ?
      `ACP_FRAME_STAT : `ACP_FRAME_DATA;
  wire logic reg_last = (addr_r >= `ACP_LAST_REG) |
      ~cmd_hold.multi_access_bit;
  wire logic [31:0] shift_left = {shift_r[30:0], 1'b0};

  // ========================================================================
  // Port sequencer
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    cmd_nxt = cmd_r;
    bit_nxt = bit_r;
    addr_nxt = addr_r;
    last_nxt = last_r;
    wr_nxt = 1'b0;
    wdata_nxt = wdata_r;
    take_result = 1'b0;
    mark_direct = 1'b0;
    if (port_rst) begin
      state_nxt = ST_IDLE;
      rise_nxt = '0;
      fall_nxt = '0;
      bit_nxt = '0;
      shift_nxt = direct_frame;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (rise) begin
            cmd_nxt = cmd_byte;
            rise_nxt = rise_r + 6'h01;
            if (rise_r == `ACP_DIRECT_BITS - 6'h01 && direct_pat) begin
              state_nxt = ST_DIRECT;
              mark_direct = 1'b1;
            end else if (rise_r == `ACP_CMD_BITS - 6'h01) begin
              state_nxt = ST_CMD_END;
              addr_nxt = cmd_in.addr;
            end
          end
          if (fall) begin
            // Direct data leaves from the first clock on
            shift_nxt = shift_left;
            fall_nxt = fall_r + 6'h01;
          end else if (rise_r == 6'h00 && fall_r == 6'h00) begin
            shift_nxt = direct_frame;
          end
        end
        ST_DIRECT: begin
          if (fall) begin
            shift_nxt = shift_left;
            fall_nxt = fall_r + 6'h01;
            if (fall_r == direct_len - 6'h01) begin
              state_nxt = ST_HOLD;
            end
          end
        end
        ST_CMD_END: begin
          if (fall) begin
            fall_nxt = `ACP_CMD_BITS;
            bit_nxt = '0;
            case (cmd_hold.op)
              `ACP_OP_RESULT: begin
                // Snapshot keeps the frame intact across a new result
                shift_nxt = {status_byte, result_r.data};
                take_result = 1'b1;
                state_nxt = ST_RESULT;
              end
              `ACP_OP_REG_RD: begin
                shift_nxt = {reg_rdata_i, 24'h000000};
                last_nxt = reg_last;
                addr_nxt = addr_r + 4'h1;
                state_nxt = ST_REG_RD;
              end
              `ACP_OP_REG_WR: begin
                state_nxt = ST_REG_WR;
              end
              default: begin
                state_nxt = ST_IDLE;
                rise_nxt = '0;
                fall_nxt = '0;
              end
            endcase
          end
        end
        ST_RESULT: begin
          if (fall) begin
            shift_nxt = shift_left;
            fall_nxt = fall_r + 6'h01;
            if (fall_r == `ACP_FRAME_CMD - 6'h01) begin
              state_nxt = ST_IDLE;
              rise_nxt = '0;
              fall_nxt = '0;
            end
          end
        end
        ST_REG_RD: begin
          if (fall) begin
            bit_nxt = bit_r + 3'h1;
            shift_nxt = shift_left;
            if (bit_r == `ACP_BYTE_LAST) begin
              if (last_r) begin
                state_nxt = ST_IDLE;
                rise_nxt = '0;
                fall_nxt = '0;
              end else begin
                shift_nxt = {reg_rdata_i, 24'h000000};
                last_nxt = reg_last;
                addr_nxt = addr_r + 4'h1;
              end
            end
          end
        end
        ST_REG_WR: begin
          if (wr_r) begin
            addr_nxt = addr_r + 4'h1;
            if (reg_last) begin
              state_nxt = ST_IDLE;
              rise_nxt = '0;
              fall_nxt = '0;
            end
          end
          if (rise) begin
            // Write data gathers apart so dout never moves on a rise
            wdata_nxt = {wdata_r[6:0], din_s};
            bit_nxt = bit_r + 3'h1;
            if (bit_r == `ACP_BYTE_LAST) begin
              wr_nxt = 1'b1;
            end
          end
        end
        ST_HOLD: begin
          // Commands ignored; output runs out as zeros
          if (fall) begin
            shift_nxt = shift_left;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Result, fresh flag and strobe next values
  wire logic fresh_nxt = conv_valid_i |
      (fresh_r & ~take_result);
  wire logic direct_done_nxt = conv_valid_i ? 1'b0 :
      (direct_done_r | mark_direct);
  // Strobe falls two cycles after the frame is loaded
  wire logic result_ready_strobe_n_n_nxt = new_d_r[2] ? 1'b0 :
      ((fall & ~cs_s) ? 1'b1 : result_ready_strobe_n_n_r);

  // ========================================================================
  // Sequencer registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      shift_r <= '0;
      rise_r <= '0;
      fall_r <= '0;
      cmd_r <= '0;
      bit_r <= '0;
      addr_r <= '0;
      last_r <= 1'b0;
      wr_r <= 1'b0;
      wdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      cmd_r <= cmd_nxt;
      bit_r <= bit_nxt;
      addr_r <= addr_nxt;
      last_r <= last_nxt;
      wr_r <= wr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // Result, flags, strobe and pin registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sclk_d_r <= 1'b0;
      tmo_r <= '0;
      result_r <= '0;
      fresh_r <= 1'b0;
      direct_done_r <= 1'b0;
      new_d_r <= '0;
      result_ready_strobe_n_n_r <= 1'b1;
      dout_r <= 1'b0;
      dout_oe_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      tmo_r <= tmo_nxt;
      if (conv_valid_i) begin
        result_r <= conv_result_i;
      end
      fresh_r <= fresh_nxt;
      direct_done_r <= direct_done_nxt;
      new_d_r <= {new_d_r[1:0], conv_valid_i};
      result_ready_strobe_n_n_r <= result_ready_strobe_n_n_nxt;
      dout_r <= shift_r[31];
      dout_oe_r <= ~cs_s;
    end
  end

  // ========================================================================
  // Outputs
  assign dout_o = dout_r;
  assign dout_oe_o = dout_oe_r;
  assign result_ready_strobe_n_o = result_ready_strobe_n_n_r;
  assign reg_addr_o = addr_r;
  assign reg_wr_o = wr_r;
  assign reg_wdata_o = wdata_r;

endmodule : acp_serial_port

// [dv/acp_serial_port_monitor.sv]
`timescale 1ns/100ps
// ==========================================================================
// Pin level checker of the serial command port
module acp_monitor (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  // Converter and register side
  input wire logic conv_valid_i,
  input wire logic result_ready_strobe_n_o,
  input wire logic reg_wr_o
);
  logic sclk_r;
  logic [3:0] fall_r;
  logic [3:0] rise_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // Cycles since the last serial clock fall and rise, saturating
  always_ff @(posedge core_clk_i) begin
    sclk_r <= sclk_i;
    if (reset_i || (sclk_r && !sclk_i)) begin
      fall_r <= reset_i ? 4'hf : 4'h0;
    end else if (fall_r != 4'hf) begin
      fall_r <= fall_r + 4'h1;
    end
    if (reset_i || (!sclk_r && sclk_i)) begin
      rise_r <= reset_i ? 4'hf : 4'h0;
    end else if (rise_r != 4'hf) begin
      rise_r <= rise_r + 4'h1;
    end
  end

  sequence s_desel;
    cs_n_i [*4];
  endsequence
  sequence s_ready;
    ##[2:4] !result_ready_strobe_n_o;
  endsequence

  property p_cs_float;
    s_desel |-> !dout_oe_o;
  endproperty
  a_cs_float: assert property (p_cs_float)
    else $error("dout driven while deselected");
  property p_oe_sel;
    $rose(dout_oe_o) |-> !cs_n_i && ($past(cs_n_i, 2) == 1'b0);
  endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("dout enabled without select");
  property p_strobe_rdy;
    conv_valid_i |-> s_ready;
  endproperty
  a_strobe_rdy: assert property (p_strobe_rdy)
    else $error("strobe missing after new result");
  property p_strobe_back;
    $rose(result_ready_strobe_n_o) |-> !cs_n_i && fall_r <= 4'h7;
  endproperty
  a_strobe_back: assert property (p_strobe_back)
    else $error("strobe released without a clock fall");
  property p_dout_fall;
    $changed(dout_o) && dout_oe_o && $past(dout_oe_o) && fall_r != 4'hf
      |-> fall_r <= 4'h7;
  endproperty
  a_dout_fall: assert property (p_dout_fall)
    else $error("dout moved away from a clock fall");
  property p_wr_rise;
    reg_wr_o |-> rise_r <= 4'h6;
  endproperty
  a_wr_rise: assert property (p_wr_rise)
    else $error("write pulse away from a clock rise");
  property p_wr_sel;
    reg_wr_o |-> !cs_n_i;
  endproperty
  a_wr_sel: assert property (p_wr_sel)
    else $error("write pulse while deselected");
  property p_wr_pulse;
    reg_wr_o |=> !reg_wr_o [*8];
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write pulses too close");
endmodule : acp_monitor

bind acp_serial_port acp_monitor i_mon (.core_clk_i, .reset_i, .cs_n_i,
  .sclk_i, .dout_o, .dout_oe_o, .conv_valid_i, .result_ready_strobe_n_o,
  .reg_wr_o);

// [dv/acp_host_model.sv]
`timescale 1ns/100ps
// ==========================================================================
// Host serial master: select, clock idle low, data set while clock low
module acp_host_model (
  // Clock
  input wire logic core_clk_i,
  // Device pins
  input wire logic dout_i,
  input wire logic dout_oe_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  // Pins idle before the first frame
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end

  // One frame of n clocks; an undriven dout reads as unknown
  task automatic xfer(input int n, input logic [39:0] d,
                      input logic keep, output logic [39:0] q);
    q = '0;
    cs_n_o <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    for (int i = 0; i < n; i++) begin
      din_o <= d[39-i];
      repeat (4) @(posedge core_clk_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      @(negedge core_clk_i);
      q = {q[38:0], dout_oe_i ? dout_i : 1'bx};
      @(posedge core_clk_i);
      sclk_o <= 1'b0;
    end
    repeat (8) @(posedge core_clk_i);
    if (!keep) begin
      cs_n_o <= 1'b1;
      din_o <= ~din_o;
      repeat (10) @(posedge core_clk_i);
    end
  endtask : xfer
endmodule : acp_host_model

// [dv/tb_adc_serial_command_port.sv]
`timescale 1ns/100ps
// ==========================================================================
// Bench of the serial command port
module tb_adc_serial_command_port import acp_pkg::*; ;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic conv_valid = 1'b0;
  acp_result_s conv_result = '0;
  logic tmo_sel = 1'b0;
  logic stat_en = 1'b1;
  logic cs_n, sclk, din, dout, dout_oe, strobe_n, reg_wr;
  logic [3:0] reg_addr;
  logic [3:0] wa;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] wd;
  logic [39:0] q;
  logic [31:0] rs = 32'hf2b5c881;
  logic [6:0] mf;
  logic [23:0] md;
  logic fresh;
  int wn = 0;
  int err_total = 0;
  int total_checks = 0;
  int k;

  always #20 core_clk_i = ~core_clk_i;
  // Register file stand-in: data follows the address
  assign reg_rdata = {4'h5, reg_addr};

  acp_serial_port #(.TMO_SHORT(16), .TMO_LONG(64), .RECOVER_CYCLES(200))
  i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .cs_n_i(cs_n),
    .sclk_i(sclk), .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe),
    .conv_valid_i(conv_valid), .conv_result_i(conv_result),
    .result_ready_strobe_n_o(strobe_n), .idle_timeout_select_i(tmo_sel),
    .status_enable_i(stat_en), .reg_addr_o(reg_addr),
    .reg_rdata_i(reg_rdata), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata));

  acp_host_model i_host (.core_clk_i(core_clk_i), .dout_i(dout),
    .dout_oe_i(dout_oe), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));

  // Capture of register write pulses
  always @(posedge core_clk_i) begin
    if (reg_wr === 1'b1) begin
      wn <= wn + 1;
      wa <= reg_addr;
      wd <= reg_wdata;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // New converter result; the model marks it fresh
  task automatic push();
    rs = lfsr(rs);
    @(posedge core_clk_i);
    conv_result <= acp_result_s'(rs[30:0]);
    conv_valid <= 1'b1;
    @(posedge core_clk_i);
    conv_valid <= 1'b0;
    mf = rs[30:24];
    md = rs[23:0];
    fresh = 1'b1;
    repeat (8) @(posedge core_clk_i);
  endtask : push

  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk({38'h0, strobe_n, dout_oe}, 40'h2);
    push();
    i_host.xfer(32, 40'h0, 1'b0, q);
    chk({8'h0, q[31:0]}, {8'h0, fresh, mf, md});
    // Long timeout so the held port is not freed between the frames
    stat_en <= 1'b0;
    tmo_sel <= 1'b1;
    i_host.xfer(24, '1, 1'b1, q);
    chk({16'h0, q[23:0]}, 40'h0);
    i_host.xfer(24, {8'h79, 32'h0}, 1'b0, q);
    chk(40'(wn), 40'h0);
    // Command reads after short timeout, long timeout and a select abort
    for (k = 0; k < 3; k++) begin
      push();
      tmo_sel <= k[0];
      i_host.xfer(k < 2 ? 5 : 12, {8'h30, 32'h0}, k < 2, q);
      if (k < 2) repeat (k ? 74 : 26) @(posedge core_clk_i);
      // The aborted read got past its command byte and took the result
      if (k == 2) fresh = 1'b0;
      i_host.xfer(40, {8'h30, 32'h0}, 1'b0, q);
      chk({8'h0, q[31:0]}, {8'h0, fresh, mf, md});
      fresh = 1'b0;
    end
    i_host.xfer(40, {8'h30, 32'h0}, 1'b0, q);
    chk({8'h0, q[31:0]}, {8'h0, fresh, mf, md});
    i_host.xfer(24, {8'h58, 32'h0}, 1'b0, q);
    chk({24'h0, q[15:0]}, {24'h0, 16'h5859});
    rs = lfsr(rs);
    i_host.xfer(24, {8'h79, rs[7:0], 24'h0}, 1'b0, q);
    chk({24'h0, 4'(wn), wa, wd}, {24'h0, 4'h1, 4'h9, rs[7:0]});
    test_done();
  end

  // Watchdog, several times the expected run length
  initial begin
    #1000000;
    err_total++;
    test_done();
  end
endmodule : tb_adc_serial_command_port
